// *** logic/fxc_core.sv ***
// Command interpreter: ranged CRC check, state gating, address-only read.
// Assumes op_done, arr_* and configuration inputs are on core_clk;
// sclk, cs_n, io_lane0 and rst_pin_n come from the pins.
`timescale 1ns/1ps
`default_nettype none
`include "fxc_defines.svh"
module fxc_core (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic io_lane0,
  input wire logic rst_pin_n,
  input wire logic rst_pin_en,
  input wire logic quad_mode,
  input wire logic basic_variant,
  input wire logic [2:0] nv_boot_cfg,
  input wire logic op_done,
  input wire logic arr_valid,
  input wire logic [7:0] arr_data,
  output logic arr_req,
  output logic [31:0] arr_addr,
  output logic cmd_accept,
  output logic cmd_refuse,
  output logic [7:0] cmd_code,
  output logic [31:0] cmd_addr,
  output fxc_pkg::fxc_state_t dev_state,
  output logic read_unreliable,
  output logic [7:0] vcr,
  output logic address_only_read_mode,
  output logic crc_busy,
  output logic crc_fail_flag,
  output logic [63:0] crc_result_readback
);
  // ****************************************************************
  // Link front end and crossings
  // ****************************************************************
  fxc_link_if lnk ();

  fxc_link u_link (
    .sclk(sclk),
    .cs_n(cs_n),
    .srst(srst),
    .io_lane0(io_lane0),
    .lnk(lnk)
  );

  logic cs_s1_r, cs_s2_r, cs_s3_r, cs_s4_r;
  logic tg_s1_r, tg_s2_r, tg_s3_r;
  logic rp_s1_r, rp_s2_r, rp_s3_r;

  // Extra cs stage so the last byte is always seen before frame end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
      cs_s4_r <= 1'b1;
      tg_s1_r <= 1'b0;
      tg_s2_r <= 1'b0;
      tg_s3_r <= 1'b0;
      rp_s1_r <= 1'b1;
      rp_s2_r <= 1'b1;
      rp_s3_r <= 1'b1;
    end else if (ce) begin
      cs_s1_r <= cs_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      cs_s4_r <= cs_s3_r;
      tg_s1_r <= lnk.byte_tog;
      tg_s2_r <= tg_s1_r;
      tg_s3_r <= tg_s2_r;
      rp_s1_r <= rst_pin_n;
      rp_s2_r <= rp_s1_r;
      rp_s3_r <= rp_s2_r;
    end
  end

  logic byte_evt, frame_end, pin_reset;
  logic [7:0] byte_in;

  assign byte_evt = tg_s2_r ^ tg_s3_r;
  assign byte_in = lnk.byte_data;
  assign frame_end = cs_s3_r & ~cs_s4_r; // R6
  // In quad mode the reset pin only counts while deselected
  assign pin_reset = rst_pin_en & rp_s3_r & ~rp_s2_r &
                     (~quad_mode | cs_s2_r); // R25

  // ****************************************************************
  // Frame parsing
  // ****************************************************************
  logic [4:0] idx_r, eidx;
  logic aom_frm_r, cur_aom;
  logic [7:0] cmd_r, cur_cmd, frm_cmd;
  logic [31:0] addr_r;
  logic [7:0] vcr_dat_r;
  logic crc_ok_r;
  logic [63:0] exp_sh_r;
  logic [31:0] sta_sh_r, end_sh_r;
  logic aom_r;

  // Address-only frames behave as a fast read with the command implied
  assign cur_aom = (idx_r == `FXC_IDX_CMD) ? aom_r : aom_frm_r; // R19
  assign eidx = idx_r + {4'h0, cur_aom};
  assign cur_cmd = cur_aom ? `FXC_CMD_FREAD :
                   (eidx == `FXC_IDX_CMD ? byte_in : cmd_r);
  assign frm_cmd = aom_frm_r ? `FXC_CMD_FREAD : cmd_r;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      idx_r <= 5'h00;
      aom_frm_r <= 1'b0;
      cmd_r <= 8'h00;
      addr_r <= 32'h0000_0000;
      vcr_dat_r <= 8'h00;
    end else if (ce) begin
      if (frame_end) begin
        idx_r <= 5'h00;
        addr_r <= 32'h0000_0000;
        cmd_r <= 8'h00;
      end else if (byte_evt) begin
        if (idx_r != `FXC_IDX_MAX) begin
          idx_r <= idx_r + 5'h01;
        end
        if (idx_r == `FXC_IDX_CMD) begin
          aom_frm_r <= aom_r;
        end
        if (eidx == `FXC_IDX_CMD) begin
          cmd_r <= byte_in; // R1
        end
        if (eidx >= `FXC_IDX_ADDR_LO && eidx <= `FXC_IDX_ADDR_HI) begin
          addr_r <= {addr_r[23:0], byte_in};
        end
        if (eidx == `FXC_IDX_ADDR_LO) begin
          vcr_dat_r <= byte_in;
        end
      end
    end
  end

  // Shadow copies, so a refused check leaves the engine untouched
  always_ff @(posedge core_clk) begin
    if (srst) begin
      crc_ok_r <= 1'b0;
      exp_sh_r <= 64'h0;
      sta_sh_r <= 32'h0;
      end_sh_r <= 32'h0;
    end else if (ce && byte_evt && cmd_r == `FXC_CMD_IFACE && !cur_aom) begin
      if (eidx == `FXC_IDX_SUB) begin
        crc_ok_r <= (byte_in == `FXC_CRC_SUB); // R2
      end
      if (eidx == `FXC_IDX_OPT) begin
        crc_ok_r <= crc_ok_r & (byte_in == `FXC_CRC_RANGE); // R2
      end
      if (eidx >= `FXC_IDX_EXP_LO && eidx <= `FXC_IDX_EXP_HI) begin
        exp_sh_r <= {byte_in, exp_sh_r[63:8]}; // R3
      end
      if (eidx >= `FXC_IDX_STA_LO && eidx <= `FXC_IDX_STA_HI) begin
        sta_sh_r <= {byte_in, sta_sh_r[31:8]}; // R4
      end
      if (eidx >= `FXC_IDX_END_LO && eidx <= `FXC_IDX_END_HI) begin
        end_sh_r <= {byte_in, end_sh_r[31:8]}; // R5
      end
    end
  end

  // ****************************************************************
  // Acceptance decision
  // ****************************************************************
  fxc_pkg::fxc_state_t st_r;
  fxc_pkg::fxc_op_t op_r;
  logic [31:0] dec_addr;
  logic [7:0] dec_cmd;
  logic dec_now, allow, in_susp_sector, crc_busy_r;

  function automatic logic is_read(input logic [7:0] c);
    return (c == `FXC_CMD_READ) || (c == `FXC_CMD_FREAD);
  endfunction

  logic [31:`FXC_SECTOR_LSB] susp_sector_r;

  // Reads decide on the last address byte, all else on frame end
  assign dec_now = (byte_evt && !frame_end && eidx == `FXC_IDX_ADDR_HI &&
                    is_read(cur_cmd)) ||
                   (frame_end && idx_r != 5'h00 && !is_read(frm_cmd));
  assign dec_cmd = frame_end ? frm_cmd : cur_cmd;
  assign dec_addr = frame_end ? addr_r : {addr_r[23:0], byte_in};
  assign in_susp_sector = dec_addr[31:`FXC_SECTOR_LSB] == susp_sector_r;

  always_comb begin
    allow = 1'b0;
    case (dec_cmd)
      `FXC_CMD_READ, `FXC_CMD_FREAD:
        allow = (st_r != fxc_pkg::ST_PROG_ERASE); // R10
      `FXC_CMD_RDSR, `FXC_CMD_RDFSR:
        allow = 1'b1; // R12
      `FXC_CMD_PP:
        allow = (st_r == fxc_pkg::ST_STANDBY) ||
                (st_r == fxc_pkg::ST_ERASE_SUSP && !in_susp_sector); // R13
      `FXC_CMD_SE, `FXC_CMD_SSE:
        allow = (st_r == fxc_pkg::ST_STANDBY); // R14
      `FXC_CMD_WRSR, `FXC_CMD_WRNVCR, `FXC_CMD_OTP, `FXC_CMD_DIE:
        allow = (st_r == fxc_pkg::ST_STANDBY); // R15
      `FXC_CMD_WRVCR, `FXC_CMD_WREVCR, `FXC_CMD_WREN, `FXC_CMD_WRDI,
      `FXC_CMD_CLFSR, `FXC_CMD_WRLR:
        allow = (st_r != fxc_pkg::ST_PROG_ERASE); // R16
      `FXC_CMD_SUSP:
        allow = (st_r == fxc_pkg::ST_PROG_ERASE); // R17
      `FXC_CMD_RESUME:
        allow = (st_r == fxc_pkg::ST_SSE_PROG_SUSP) ||
                (st_r == fxc_pkg::ST_ERASE_SUSP);
      `FXC_CMD_IFACE:
        allow = (st_r == fxc_pkg::ST_STANDBY) && crc_ok_r && !crc_busy_r &&
                (idx_r == `FXC_IDX_CRC_LEN); // R1 R6
      default:
        allow = 1'b0; // R26
    endcase
  end

  logic acc;
  assign acc = dec_now & allow;

  // Refused commands only pulse cmd_refuse; nothing else moves except aom_r and vcr, which a refused fast read's confirm bit can still change
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmd_accept <= 1'b0;
      cmd_refuse <= 1'b0;
      cmd_code <= 8'h00;
      cmd_addr <= 32'h0000_0000;
      read_unreliable <= 1'b0;
    end else if (ce) begin
      cmd_accept <= acc;
      cmd_refuse <= dec_now & ~allow; // R26
      if (acc) begin
        cmd_code <= dec_cmd;
        cmd_addr <= dec_addr;
        read_unreliable <= is_read(dec_cmd) && in_susp_sector &&
                           st_r == fxc_pkg::ST_ERASE_SUSP; // R11
      end
    end
  end

  // ****************************************************************
  // Device state
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= fxc_pkg::ST_STANDBY;
      op_r <= fxc_pkg::OP_OTHER;
      susp_sector_r <= '0;
    end else if (ce) begin
      case (st_r) // R9
        fxc_pkg::ST_STANDBY: begin
          if (acc) begin
            case (dec_cmd)
              `FXC_CMD_PP, `FXC_CMD_OTP: begin
                st_r <= fxc_pkg::ST_PROG_ERASE;
                op_r <= fxc_pkg::OP_PROG;
              end
              `FXC_CMD_SSE: begin
                st_r <= fxc_pkg::ST_PROG_ERASE;
                op_r <= fxc_pkg::OP_SUBSECTOR;
              end
              `FXC_CMD_SE: begin
                st_r <= fxc_pkg::ST_PROG_ERASE;
                op_r <= fxc_pkg::OP_SECTOR;
                susp_sector_r <= dec_addr[31:`FXC_SECTOR_LSB];
              end
              `FXC_CMD_WRSR, `FXC_CMD_WRNVCR, `FXC_CMD_DIE: begin
                st_r <= fxc_pkg::ST_PROG_ERASE;
                op_r <= fxc_pkg::OP_OTHER;
              end
              default: begin
                st_r <= st_r;
              end
            endcase
          end
        end
        fxc_pkg::ST_PROG_ERASE: begin
          if (op_done) begin
            st_r <= fxc_pkg::ST_STANDBY;
          end else if (acc && dec_cmd == `FXC_CMD_SUSP) begin
            st_r <= (op_r == fxc_pkg::OP_SECTOR) ?
                    fxc_pkg::ST_ERASE_SUSP : fxc_pkg::ST_SSE_PROG_SUSP;
          end
        end
        fxc_pkg::ST_SSE_PROG_SUSP, fxc_pkg::ST_ERASE_SUSP: begin
          if (acc && dec_cmd == `FXC_CMD_RESUME) begin
            st_r <= fxc_pkg::ST_PROG_ERASE;
          end
        end
        default: begin
          st_r <= fxc_pkg::ST_STANDBY;
        end
      endcase
    end
  end

  assign dev_state = st_r;

  // ****************************************************************
  // Address-only read mode and volatile configuration
  // ****************************************************************
  logic boot_pend_r, confirm_evt, confirm_bit, aom_enabled;

  // Confirm bit is the first dummy clock on lane 0 of a fast read
  assign confirm_evt = byte_evt && !frame_end &&
                       eidx == `FXC_IDX_DUMMY &&
                       cur_cmd == `FXC_CMD_FREAD; // R23
  assign confirm_bit = byte_in[`FXC_CONFIRM_BIT]; // R23 R24
  assign aom_enabled = aom_r || basic_variant ||
                       !vcr[`FXC_VCR_XIP_BIT]; // R18 R21

  // Boot choice is caught by a clocked step after reset release
  always_ff @(posedge core_clk) begin
    if (srst) begin
      boot_pend_r <= 1'b1;
      aom_r <= 1'b0;
    end else if (ce) begin
      boot_pend_r <= 1'b0;
      if (boot_pend_r || pin_reset) begin
        aom_r <= (nv_boot_cfg != `FXC_NV_BOOT_OFF); // R22 R25
      end else if (confirm_evt) begin
        if (confirm_bit) begin
          aom_r <= 1'b0; // R20
        end else if (aom_enabled) begin
          aom_r <= 1'b1; // R18 R21
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      vcr <= `FXC_VCR_RST;
    end else if (ce) begin
      if (pin_reset) begin
        vcr <= `FXC_VCR_RST; // R25
      end else if (confirm_evt && confirm_bit && aom_r) begin
        vcr[`FXC_VCR_XIP_BIT] <= 1'b1; // R20
      end else if (acc && dec_cmd == `FXC_CMD_WRVCR) begin
        vcr <= vcr_dat_r; // R16
      end
    end
  end

  assign address_only_read_mode = aom_r;

  // ****************************************************************
  // Ranged CRC engine
  // ****************************************************************
  logic [63:0] crc_r, crc_nxt, exp_r;
  logic [31:0] end_r;
  logic crc_start, crc_last, crc_miss, flag_clr;

  function automatic logic [63:0] crc_byte(input logic [63:0] c,
                                           input logic [7:0] d);
    logic [63:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[63] ^ d[i]) begin
        r = {r[62:0], 1'b0} ^ `FXC_CRC_POLY;
      end else begin
        r = {r[62:0], 1'b0};
      end
    end
    return r;
  endfunction

  assign crc_start = acc && dec_cmd == `FXC_CMD_IFACE; // R6
  assign crc_nxt = crc_byte(crc_r, arr_data); // R7
  assign crc_last = crc_busy_r && arr_valid && (arr_addr == end_r);
  assign crc_miss = crc_last && (crc_nxt != exp_r); // R8
  assign flag_clr = acc && dec_cmd == `FXC_CMD_CLFSR;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      crc_busy_r <= 1'b0;
      crc_r <= 64'h0;
      exp_r <= 64'h0;
      end_r <= 32'h0;
      arr_addr <= 32'h0;
    end else if (ce) begin
      if (crc_start) begin
        crc_busy_r <= 1'b1;
        crc_r <= 64'h0; // R7
        exp_r <= exp_sh_r; // R3
        end_r <= end_sh_r; // R5
        arr_addr <= sta_sh_r; // R4
      end else if (crc_busy_r && arr_valid) begin
        crc_r <= crc_nxt; // R7
        if (crc_last) begin
          crc_busy_r <= 1'b0;
        end else begin
          arr_addr <= arr_addr + 32'h1;
        end
      end
    end
  end

  // A mismatch in the same cycle as a flag clear still sets the flag
  always_ff @(posedge core_clk) begin
    if (srst) begin
      crc_fail_flag <= 1'b0;
      crc_result_readback <= 64'h0;
    end else if (ce) begin
      if (crc_miss) begin
        crc_fail_flag <= 1'b1; // R8
        crc_result_readback <= crc_nxt;
      end else begin
        if (flag_clr) begin
          crc_fail_flag <= 1'b0;
        end
        if (crc_start) begin
          crc_result_readback <= 64'h0;
        end
      end
    end
  end

  assign arr_req = crc_busy_r;
  assign crc_busy = crc_busy_r;
endmodule
`default_nettype wire

// *** logic/fxc_defines.svh ***
// Constants for the flash command, state and address-only read block.
// Assumes inclusion by bare name from every file that decodes commands.
//
// How it works
// R1 - Ranged check opens with activation byte
// R2 - Byte 2 sub-command, byte 3 range option
// R3 - Bytes 4-11 expected CRC, LSB first
// R4 - Bytes 12-15 range start address, LSB first
// R5 - Bytes 16-19 range end address, LSB first
// R6 - Check starts only on chip-select rise
// R7 - CRC-64, bit stream LSB first, zero seed
// R8 - Mismatch reported in flag status bit 4
// R9 - Exactly one device state drives acceptance
// R10 - Array reads refused only while busy
// R11 - Read in suspended sector marked unreliable
// R12 - Status and flag reads always accepted
// R13 - Program: standby, or unsuspended sector
// R14 - Sector erases accepted in standby only
// R15 - Nonvolatile writes and die erase: standby only
// R16 - Volatile writes refused only while busy
// R17 - Suspend accepted only while busy
// R18 - Enable bit clear, then confirm zero enters
// R19 - Address-only frames carry no command byte
// R20 - Confirm one exits and restores enable bit
// R21 - Basic variant enters without enable bit
// R22 - Boot field selects address-only at power-up
// R23 - Confirm bit is lane 0, first dummy
// R24 - Lanes 1 to 3 ignored in dummy
// R25 - Reset pin restores boot state; quad deselected
// R26 - Refused command changes nothing; a refused fast read still applies its confirm bit to the mode and enable bit
`ifndef FXC_DEFINES_SVH
`define FXC_DEFINES_SVH

// ****************************************************************
// Command codes
// ****************************************************************
`define FXC_CMD_IFACE 8'h9b
`define FXC_CRC_SUB 8'h27
`define FXC_CRC_RANGE 8'hfe
`define FXC_CMD_READ 8'h03
`define FXC_CMD_FREAD 8'h0b
`define FXC_CMD_RDSR 8'h05
`define FXC_CMD_RDFSR 8'h70
`define FXC_CMD_PP 8'h02
`define FXC_CMD_OTP 8'h42
`define FXC_CMD_SE 8'hd8
`define FXC_CMD_SSE 8'h20
`define FXC_CMD_WRSR 8'h01
`define FXC_CMD_WRNVCR 8'hb1
`define FXC_CMD_DIE 8'hc4
`define FXC_CMD_WRVCR 8'h81
`define FXC_CMD_WREVCR 8'h61
`define FXC_CMD_WREN 8'h06
`define FXC_CMD_WRDI 8'h04
`define FXC_CMD_CLFSR 8'h50
`define FXC_CMD_WRLR 8'he5
`define FXC_CMD_SUSP 8'h75
`define FXC_CMD_RESUME 8'h7a

// ****************************************************************
// Byte positions within a frame
// ****************************************************************
`define FXC_IDX_CMD 5'h00
`define FXC_IDX_SUB 5'h01
`define FXC_IDX_OPT 5'h02
`define FXC_IDX_ADDR_LO 5'h01
`define FXC_IDX_ADDR_HI 5'h03
`define FXC_IDX_DUMMY 5'h04
`define FXC_IDX_EXP_LO 5'h03
`define FXC_IDX_EXP_HI 5'h0a
`define FXC_IDX_STA_LO 5'h0b
`define FXC_IDX_STA_HI 5'h0e
`define FXC_IDX_END_LO 5'h0f
`define FXC_IDX_END_HI 5'h12
`define FXC_IDX_CRC_LEN 5'h13
`define FXC_IDX_MAX 5'h1f

// ****************************************************************
// Fields, reset values, polynomial
// ****************************************************************
`define FXC_VCR_XIP_BIT 3
`define FXC_VCR_RST 8'hff
`define FXC_NV_BOOT_OFF 3'h7
`define FXC_CONFIRM_BIT 7
`define FXC_SECTOR_LSB 16
`define FXC_CRC_POLY 64'h42f0e1eba9ea3693

`endif

// *** logic/fxc_link.sv ***
// Serial-clock front end: shifts lane 0 into bytes.
// Assumes the host holds sclk still while chip select is high.
`timescale 1ns/1ps
`default_nettype none
module fxc_link (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic srst,
  input wire logic io_lane0,
  fxc_link_if.src lnk
);
  logic [2:0] bit_cnt_r;
  logic [6:0] shf_r;

  // Chip select high restarts byte alignment without any sclk edge
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_r <= 3'h0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  // Only lane 0 is sampled, so upper lanes never reach the confirm bit
  always_ff @(posedge sclk) begin
    shf_r <= {shf_r[5:0], io_lane0}; // R24
  end

  always_ff @(posedge sclk) begin
    if (bit_cnt_r == 3'h7) begin
      lnk.byte_data <= {shf_r, io_lane0};
    end
  end

  // Toggle carries the byte event across; data held for a byte time
  always_ff @(posedge sclk or posedge srst) begin
    if (srst) begin
      lnk.byte_tog <= 1'b0;
    end else if (bit_cnt_r == 3'h7) begin
      lnk.byte_tog <= ~lnk.byte_tog;
    end
  end
endmodule
`default_nettype wire

// *** logic/fxc_link_if.sv ***
// Byte hand-over from the serial-clock side to the core clock side.
// Assumes byte_data is stable for a whole byte time after byte_tog flips.
`timescale 1ns/1ps
`default_nettype none
interface fxc_link_if;
  logic [7:0] byte_data;
  logic byte_tog;
  modport src (output byte_data, output byte_tog);
  modport dst (input byte_data, input byte_tog);
endinterface
`default_nettype wire

// *** logic/fxc_pkg.sv ***
// Types shared by the flash command block.
// Assumes no other package.
`default_nettype none
package fxc_pkg;
  typedef enum logic [1:0] {
    ST_STANDBY, ST_PROG_ERASE, ST_SSE_PROG_SUSP, ST_ERASE_SUSP
  } fxc_state_t;
  typedef enum logic [1:0] {
    OP_PROG, OP_SUBSECTOR, OP_SECTOR, OP_OTHER
  } fxc_op_t;
endpackage
`default_nettype wire

// *** tb/fxc_core_monitor.sv ***
// Checker for the flash command core, bound to its ports.
// Assumes ce high while checking and srst synchronous.
`timescale 1ns/1ps
`default_nettype none
module fxc_core_monitor (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic op_done,
  input wire logic arr_valid,
  input wire logic cmd_accept,
  input wire logic cmd_refuse,
  input wire fxc_pkg::fxc_state_t dev_state,
  input wire logic [31:0] arr_addr,
  input wire logic [7:0] vcr,
  input wire logic address_only_read_mode,
  input wire logic crc_busy,
  input wire logic crc_fail_flag,
  input wire logic [63:0] crc_result_readback
);
  // ****
  // Properties
  // ****
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst || !ce);
  one_answer_a: assert property (!(cmd_accept && cmd_refuse))
    else $error("accept and refuse together");
  accept_pulse_a: assert property (cmd_accept |=> !cmd_accept)
    else $error("accept longer than a cycle");
  refuse_keep_a: assert property (cmd_refuse && !op_done |=>
    $stable(dev_state))
    else $error("refused command moved state");
  crc_start_a: assert property ($rose(crc_busy) |-> cmd_accept &&
    crc_result_readback == 64'h0)
    else $error("check started without accept");
  fail_end_a: assert property ($rose(crc_fail_flag) |-> $fell(crc_busy))
    else $error("fail flag not at end of check");
  addr_step_a: assert property (crc_busy && arr_valid ##1 crc_busy |->
    arr_addr == $past(arr_addr) + 32'h1)
    else $error("range address did not step");
  susp_entry_a: assert property ($changed(dev_state) && dev_state[1] |->
    $past(dev_state) == fxc_pkg::ST_PROG_ERASE)
    else $error("suspend entered from wrong state");
  done_exit_a: assert property (
    $past(dev_state) == fxc_pkg::ST_PROG_ERASE &&
    dev_state == fxc_pkg::ST_STANDBY |-> $past(op_done) || $past(op_done, 2))
    else $error("busy state left without done");
  exit_enable_a: assert property ($fell(address_only_read_mode) |->
    vcr[3])
    else $error("enable bit not restored on exit");
  cover property ($rose(crc_fail_flag));
  cover property ($rose(address_only_read_mode));
  cover property (dev_state == fxc_pkg::ST_ERASE_SUSP && cmd_refuse);
endmodule
bind fxc_core fxc_core_monitor mon (.core_clk(core_clk), .srst(srst), .ce(ce),
  .op_done(op_done), .arr_valid(arr_valid), .cmd_accept(cmd_accept),
  .cmd_refuse(cmd_refuse), .dev_state(dev_state), .arr_addr(arr_addr),
  .vcr(vcr), .address_only_read_mode(address_only_read_mode),
  .crc_busy(crc_busy), .crc_fail_flag(crc_fail_flag),
  .crc_result_readback(crc_result_readback));
`default_nettype wire

// *** tb/fxc_host_model.sv ***
// Host controller model driving chip select, serial clock and lane 0.
// Assumes callers run one frame at a time.
`timescale 1ns/1ps
`default_nettype none
module fxc_host_model (
  output var logic cs_n,
  output var logic sclk,
  output var logic io_lane0
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io_lane0 = 1'b0;
  end
  // Clock idles low outside frames; odd start offset keeps phase loose
  task automatic frame(input logic [7:0] q[$]);
    #37 cs_n = 1'b0;
    foreach (q[i]) begin
      for (int b = 7; b >= 0; b--) begin
        io_lane0 = q[i][b];
        #80 sclk = 1'b1;
        #80 sclk = 1'b0;
      end
    end
    #80 cs_n = 1'b1;
    io_lane0 = ~io_lane0;
    #400;
  endtask
endmodule
`default_nettype wire

// *** tb/tb_flash_crc_state_xip_control.sv ***
// Bench for the flash command core: state table, ranged check, read mode.
// Assumes the host model owns the pins; fixed array data.
`timescale 1ns/1ps
`default_nettype none
`include "fxc_defines.svh"
module tb_flash_crc_state_xip_control;
  localparam logic [7:0] ARR_BYTE = 8'ha5;
  logic core_clk, srst, ce, rst_pin_n, rst_pin_en, quad_mode, basic_variant;
  logic op_done, arr_valid, arr_req, cmd_accept, cmd_refuse;
  logic read_unreliable, address_only_read_mode, crc_busy, crc_fail_flag;
  logic [2:0] nv_boot_cfg;
  logic [7:0] arr_data, cmd_code, vcr, last;
  logic [31:0] arr_addr, cmd_addr;
  logic [63:0] crc_result_readback, e;
  logic [23:0] r;
  fxc_pkg::fxc_state_t dev_state;
  wire logic cs_n, sclk, io_lane0;
  int n_mismatch = 0, check_count = 0, n_acc = 0, n_ref = 0;
  // Row: done, code, address byte, accept, state, unreliable
  logic [23:0] rows [0:37] = '{
    24'h003008, 24'h005008, 24'h075000, 24'h0d801a,
    24'h003002, 24'h07000a, 24'h002002, 24'h006002,
    24'h07500e, 24'h00301f, 24'h00302e, 24'h002016,
    24'h00202e, 24'h020006, 24'h001006, 24'h00600e,
    24'h075006, 24'h07a00a, 24'h12000a, 24'h07500c,
    24'h002004, 24'h05000c, 24'h00300c, 24'h042004,
    24'h07a00a, 24'h14200a, 24'h10200a, 24'h07500c,
    24'h07a00a, 24'h1b100a, 24'h181ff8, 24'h061ff8,
    24'h004008, 24'h0e5ff8, 24'h099ff0, 24'h0c400a,
    24'h10100a, 24'h10bff8};
  fxc_host_model host (.cs_n(cs_n), .sclk(sclk), .io_lane0(io_lane0));
  fxc_core dut (.core_clk(core_clk), .srst(srst), .ce(ce), .sclk(sclk),
    .cs_n(cs_n), .io_lane0(io_lane0), .rst_pin_n(rst_pin_n),
    .rst_pin_en(rst_pin_en), .quad_mode(quad_mode),
    .basic_variant(basic_variant), .nv_boot_cfg(nv_boot_cfg),
    .op_done(op_done), .arr_valid(arr_valid), .arr_data(arr_data),
    .arr_req(arr_req), .arr_addr(arr_addr), .cmd_accept(cmd_accept),
    .cmd_refuse(cmd_refuse), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
    .dev_state(dev_state), .read_unreliable(read_unreliable), .vcr(vcr),
    .address_only_read_mode(address_only_read_mode), .crc_busy(crc_busy),
    .crc_fail_flag(crc_fail_flag),
    .crc_result_readback(crc_result_readback));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Array stalls every other cycle
  always @(posedge core_clk) begin
    arr_valid <= ~arr_valid;
    if (cmd_accept === 1'b1) n_acc++;
    if (cmd_refuse === 1'b1) n_ref++;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] x, g);
    check_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic send(input logic [7:0] q[$], input logic acc);
    int a0;
    int r0;
    a0 = n_acc;
    r0 = n_ref;
    host.frame(q);
    chk("accepts", 64'(acc), 64'(n_acc - a0));
    chk("refusals", 64'(!acc), 64'(n_ref - r0));
  endtask
  // Zero seed, bits fed low first, no final inversion
  function automatic logic [63:0] crc_ref(input int n);
    logic [63:0] c;
    logic fb;
    c = 64'h0;
    for (int k = 0; k < n * 8; k++) begin
      fb = c[63] ^ ARR_BYTE[k % 8];
      c = {c[62:0], 1'b0} ^ (fb ? `FXC_CRC_POLY : 64'h0);
    end
    return c;
  endfunction
  task automatic crc_run(input logic [63:0] x, input int len, input logic acc);
    logic [7:0] q[$];
    logic [127:0] p;
    p = {32'h13, 32'h10, x};
    q = {8'h9b, 8'h27, 8'hfe};
    for (int i = 0; i < 16; i++) q.push_back(p[8*i +: 8]);
    while (q.size() > len) q.pop_back();
    send(q, acc);
    repeat (20) @(posedge core_clk);
  endtask
  initial begin
    #(60000 * 40);
    n_mismatch++;
    $display("timeout");
    final_report();
  end
  initial begin
    srst <= 1'b1;
    ce <= 1'b1;
    rst_pin_n <= 1'b1;
    rst_pin_en <= 1'b1;
    quad_mode <= 1'b0;
    basic_variant <= 1'b0;
    nv_boot_cfg <= 3'h7;
    op_done <= 1'b0;
    arr_valid <= 1'b0;
    arr_data <= ARR_BYTE;
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("vcr", 64'hff, 64'(vcr));
    chk("mode", 64'h0, 64'(address_only_read_mode));
    $display("test reset done");
    foreach (rows[i]) begin
      r = rows[i];
      if (r[20]) begin
        @(posedge core_clk) op_done <= 1'b1;
        @(posedge core_clk) op_done <= 1'b0;
      end
      send({r[19:12], r[11:4], r[11:4], r[11:4], r[11:4]}, r[3]);
      if (r[3]) last = r[19:12];
      chk("state", 64'(r[2:1]), 64'(dev_state));
      chk("code", 64'(last), 64'(cmd_code));
      if (r[19:12] == 8'h03)
        chk("unrel", 64'(r[0]), 64'(read_unreliable));
    end
    $display("test state table done");
    e = crc_ref(4);
    crc_run(e, 19, 1'b1);
    chk("flag", 64'h0, 64'(crc_fail_flag));
    crc_run(e ^ 64'h100, 19, 1'b1);
    chk("flag", 64'h1, 64'(crc_fail_flag));
    chk("readback", e, crc_result_readback);
    crc_run(64'h0, 18, 1'b0);
    chk("readback", e, crc_result_readback);
    send({8'h50, 8'h00}, 1'b1);
    chk("flag", 64'h0, 64'(crc_fail_flag));
    $display("test range check done");
    send({8'h81, 8'hf7, 8'hf7, 8'hf7, 8'hff}, 1'b1);
    chk("vcr", 64'hf7, 64'(vcr));
    send({8'h0b, 8'h00, 8'h00, 8'h00, 8'h7f}, 1'b1);
    chk("mode", 64'h1, 64'(address_only_read_mode));
    send({8'h12, 8'h34, 8'h56, 8'h7f}, 1'b1);
    chk("code", 64'h0b, 64'(cmd_code));
    chk("addr", 64'h123456, 64'(cmd_addr));
    send({8'h00, 8'h00, 8'h00, 8'h80}, 1'b1);
    chk("mode", 64'h0, 64'(address_only_read_mode));
    chk("vcr", 64'hff, 64'(vcr));
    @(posedge core_clk) basic_variant <= 1'b1;
    send({8'h0b, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b1);
    chk("mode", 64'h1, 64'(address_only_read_mode));
    @(posedge core_clk) rst_pin_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_pin_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk("mode", 64'h0, 64'(address_only_read_mode));
    $display("test read mode done");
    @(posedge core_clk) basic_variant <= 1'b0;
    send({8'hd8, 8'h00, 8'h00, 8'h00}, 1'b1);
    @(posedge core_clk) srst <= 1'b1;
    nv_boot_cfg <= 3'h0;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("state", 64'h0, 64'(dev_state));
    chk("mode", 64'h1, 64'(address_only_read_mode));
    $display("test mid reset done");
    final_report();
  end
endmodule
`default_nettype wire
